/* hw/light_i2c_params.svh */
/*
  Constants of the two-wire word link: addresses, codes, reset values
  and timing counts. Assumes a 200 MHz system clock on both ends.
*/
// Contract
// - Write: start, addr+W, cmd, low, high, stop.
// - Read: cmd write, restart, low acked, high not.
// - Seven 16-bit registers selected by command code.
// - Strap high: answer to address 1001000.
// - Strap low: answer to address 0010000.
// - First byte bit zero: 0 write, 1 read.
// - Serial clock kept between 10 and 400 kHz.
// - Line low 25 to 35 ms aborts transfer.
// - Interrupt pin is open drain, low active.
`ifndef LIGHT_I2C_PARAMS_SVH
`define LIGHT_I2C_PARAMS_SVH

`define TGT_ADDR_HI 7'h48
`define TGT_ADDR_LO 7'h10
`define CMD_CONF 3'h0
`define CMD_HIGH_THR 3'h1
`define CMD_LOW_THR 3'h2
`define CMD_POWER 3'h3
`define CMD_ALS 3'h4
`define CMD_WHITE 3'h5
`define CMD_INT_FLAGS 3'h6
`define CONF_RESET 16'h0001
`define CLK_KHZ 200000
`define TIMEOUT_MS 25
`define TIMEOUT_CYC (`TIMEOUT_MS * `CLK_KHZ)
`define SCL_KHZ_MIN 10
`define SCL_KHZ 400
`define SCL_QTR_CYC (`CLK_KHZ / (4 * `SCL_KHZ))

`endif

/* hw/light_i2c_pkg.sv */
/*
  Types shared by both ends of the two-wire word link.
  Assumes the constants header is on the include path.
*/
package light_i2c_pkg;

  // Target states, Gray coded along the usual transfer path.
  typedef enum logic [3:0] {
    D_IDLE = 4'h0,
    D_ADDR = 4'h1,
    D_AACK = 4'h3,
    D_CMD  = 4'h2,
    D_CACK = 4'h6,
    D_WDAT = 4'h7,
    D_WACK = 4'h5,
    D_TX   = 4'h4,
    D_MACK = 4'hc
  } dev_state_t;

  typedef enum logic [1:0] {
    H_IDLE  = 2'h0,
    H_START = 2'h1,
    H_BITS  = 2'h3,
    H_STOP  = 2'h2
  } host_state_t;

  typedef struct packed {
    logic scl_m, scl_s, scl_d;
    logic sda_m, sda_s, sda_d;
    logic strap_m, strap_s;
    dev_state_t st;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic [7:0] tx;
    logic [2:0] cmd;
    logic rd;
    logic [1:0] wbytes;
    logic [7:0] lo;
    logic [15:0] rword;
    logic hi_sent;
    logic sda_oe;
    logic int_oe;
    logic [22:0] tmo;
    logic [3:0][15:0] regs;
  } dev_reg_t;

  typedef struct packed {
    logic sda_m, sda_s;
    host_state_t st;
    logic [12:0] div;
    logic [1:0] ph;
    logic [3:0] bitn;
    logic [2:0] idx;
    logic rd;
    logic [6:0] addr;
    logic [7:0] cmd;
    logic [15:0] wdata;
    logic [7:0] tx;
    logic [7:0] rx;
    logic ack_bad;
    logic scl_oe;
    logic sda_oe;
    logic done;
    logic nack;
    logic [15:0] rdata;
  } host_reg_t;

endpackage

/* hw/light_i2c_if.sv */
/*
  Open-drain clock, data and interrupt wires between controller and
  target. Assumes pull-ups: a wire is low only while someone drives it.
*/
`timescale 1ns/10ps
`default_nettype none
interface light_i2c_if;
  logic scl_host_o, scl_host_oe;
  logic sda_host_o, sda_host_oe;
  logic sda_dev_o, sda_dev_oe;
  logic int_dev_o, int_dev_oe;
  logic scl, sda, int_n;

  // Wired-AND with pull-ups resolves each line.
  assign scl = scl_host_oe ? scl_host_o : 1'b1;
  assign sda = (sda_host_oe ? sda_host_o : 1'b1) &
               (sda_dev_oe ? sda_dev_o : 1'b1);
  assign int_n = int_dev_oe ? int_dev_o : 1'b1;

  modport target (input scl, sda, output sda_dev_o, sda_dev_oe,
                  output int_dev_o, int_dev_oe);
  modport ctrl (input scl, sda, int_n, output scl_host_o,
                output scl_host_oe, sda_host_o, sda_host_oe);
endinterface
`default_nettype wire

/* hw/light_i2c_target.sv */
/*
  Target end of the two-wire word link: address match, command code,
  16-bit register writes and reads, bus timeout and interrupt pin.
  Assumes clk at 200 MHz, well above sixteen times the serial clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "light_i2c_params.svh"
module light_i2c_target #(
  parameter int unsigned TIMEOUT_CYC = `TIMEOUT_CYC
) (
  input wire logic clk,                  // System clock.
  input wire logic resetn,               // Asynchronous reset, low.
  light_i2c_if.target bus,               // Serial link pins.
  input wire logic addr_strap,           // Address select pin.
  input wire logic [15:0] als_data,      // Light result word.
  input wire logic [15:0] white_data,    // White result word.
  input wire logic [15:0] int_flags,     // Trigger event word.
  input wire logic int_req,              // Interrupt request.
  output logic [15:0] conf_word,         // Configuration register.
  output logic [15:0] high_thr,          // High threshold register.
  output logic [15:0] low_thr,           // Low threshold register.
  output logic [15:0] power_word,        // Power saving register.
  output logic busy                      // Transaction in progress.
);
  import light_i2c_pkg::*;

  // ********************************************************
  // State and reset value
  // ********************************************************
  localparam dev_reg_t RST = '{
    scl_m: 1'b1, scl_s: 1'b1, scl_d: 1'b1,
    sda_m: 1'b1, sda_s: 1'b1, sda_d: 1'b1,
    strap_m: 1'b0, strap_s: 1'b0,
    st: D_IDLE, cnt: 4'h0, shift: 8'h00, tx: 8'h00,
    cmd: 3'h0, rd: 1'b0, wbytes: 2'h0, lo: 8'h00,
    rword: 16'h0000, hi_sent: 1'b0, sda_oe: 1'b0,
    int_oe: 1'b0, tmo: 23'h000000,
    regs: {16'h0000, 16'h0000, 16'h0000, `CONF_RESET}
  };

  dev_reg_t r_reg, r_next;
  logic scl_rise, scl_fall, start_seen, stop_seen;
  logic [6:0] my_addr;
  logic tmo_hit;
  logic [15:0] rd_word;

  // Read mux over the command codes; an undefined code reads zero.
  function automatic logic [15:0] read_word(input dev_reg_t r,
                                            input logic [2:0] c);
    logic [15:0] w;
    w = 16'h0000;
    unique case (c)
      `CMD_CONF, `CMD_HIGH_THR,
      `CMD_LOW_THR, `CMD_POWER: w = r.regs[c[1:0]];
      `CMD_ALS: w = als_data;
      `CMD_WHITE: w = white_data;
      `CMD_INT_FLAGS: w = int_flags;
      default: w = 16'h0000;
    endcase
    return w;
  endfunction

  // ********************************************************
  // Line events
  // ********************************************************
  // Edges are taken between the second and third flops only.
  assign scl_rise = r_reg.scl_s & ~r_reg.scl_d;
  assign scl_fall = ~r_reg.scl_s & r_reg.scl_d;
  assign start_seen = r_reg.scl_s & r_reg.scl_d &
                      r_reg.sda_d & ~r_reg.sda_s;
  assign stop_seen = r_reg.scl_s & r_reg.scl_d &
                     ~r_reg.sda_d & r_reg.sda_s;
  assign my_addr = r_reg.strap_s ? `TGT_ADDR_HI : `TGT_ADDR_LO;
  assign tmo_hit = (r_reg.tmo == 23'(TIMEOUT_CYC));
  // The word to send is picked here so that its bytes can be sliced.
  assign rd_word = read_word(r_reg, r_reg.cmd);

  // ********************************************************
  // Next state
  // ********************************************************
  always_comb begin
    r_next = r_reg;
    r_next.scl_m = bus.scl;
    r_next.scl_s = r_reg.scl_m;
    r_next.scl_d = r_reg.scl_s;
    r_next.sda_m = bus.sda;
    r_next.sda_s = r_reg.sda_m;
    r_next.sda_d = r_reg.sda_s;
    r_next.strap_m = addr_strap;
    r_next.strap_s = r_reg.strap_m;
    r_next.int_oe = int_req;

    // Any clock edge or a fully idle bus restarts the low-time count.
    if (scl_rise | scl_fall | (r_reg.scl_s & r_reg.sda_s)) begin
      r_next.tmo = 23'h000000;
    end else if (!tmo_hit) begin
      r_next.tmo = r_reg.tmo + 23'h000001;
    end

    if (start_seen) begin
      // A repeated start is a start as well.
      r_next.st = D_ADDR;
      r_next.cnt = 4'h0;
      r_next.sda_oe = 1'b0;
    end else if (stop_seen || tmo_hit) begin
      r_next.st = D_IDLE;
      r_next.sda_oe = 1'b0;
    end else begin
      unique case (r_reg.st)
        D_IDLE: r_next.sda_oe = 1'b0;
        D_ADDR, D_CMD, D_WDAT: begin
          if (scl_rise && r_reg.cnt != 4'h8) begin
            r_next.shift = {r_reg.shift[6:0], r_reg.sda_s};
            r_next.cnt = r_reg.cnt + 4'h1;
          end else if (scl_fall && r_reg.cnt == 4'h8) begin
            r_next.sda_oe = 1'b1;
            if (r_reg.st == D_ADDR) begin
              if (r_reg.shift[7:1] == my_addr) begin
                r_next.rd = r_reg.shift[0];
                r_next.st = D_AACK;
              end else begin
                r_next.sda_oe = 1'b0;
                r_next.st = D_IDLE;
              end
            end else if (r_reg.st == D_CMD) begin
              r_next.cmd = r_reg.shift[2:0];
              r_next.st = D_CACK;
            end else if (r_reg.wbytes == 2'h0) begin
              r_next.lo = r_reg.shift;
              r_next.wbytes = 2'h1;
              r_next.st = D_WACK;
            end else if (r_reg.wbytes == 2'h1) begin
              // Codes above the power word are read only.
              if (!r_reg.cmd[2]) begin
                r_next.regs[r_reg.cmd[1:0]] =
                  {r_reg.shift, r_reg.lo};
              end
              r_next.wbytes = 2'h2;
              r_next.st = D_WACK;
            end else begin
              // A third data byte is refused.
              r_next.sda_oe = 1'b0;
              r_next.st = D_IDLE;
            end
          end
        end
        D_AACK: begin
          if (scl_fall) begin
            r_next.cnt = 4'h0;
            if (r_reg.rd) begin
              r_next.rword = rd_word;
              r_next.tx = rd_word[7:0];
              r_next.sda_oe = ~rd_word[7];
              r_next.hi_sent = 1'b0;
              r_next.st = D_TX;
            end else begin
              r_next.sda_oe = 1'b0;
              r_next.st = D_CMD;
            end
          end
        end
        D_CACK: begin
          if (scl_fall) begin
            r_next.sda_oe = 1'b0;
            r_next.cnt = 4'h0;
            r_next.wbytes = 2'h0;
            r_next.st = D_WDAT;
          end
        end
        D_WACK: begin
          if (scl_fall) begin
            r_next.sda_oe = 1'b0;
            r_next.cnt = 4'h0;
            r_next.st = D_WDAT;
          end
        end
        D_TX: begin
          if (scl_fall) begin
            if (r_reg.cnt == 4'h7) begin
              r_next.sda_oe = 1'b0;
              r_next.st = D_MACK;
            end else begin
              r_next.tx = {r_reg.tx[6:0], 1'b0};
              r_next.sda_oe = ~r_reg.tx[6];
              r_next.cnt = r_reg.cnt + 4'h1;
            end
          end
        end
        D_MACK: begin
          // Low byte acked gives the high byte; a no-ack ends it.
          if (scl_rise) begin
            if (r_reg.sda_s || r_reg.hi_sent) begin
              r_next.st = D_IDLE;
            end
          end else if (scl_fall) begin
            r_next.cnt = 4'h0;
            r_next.hi_sent = 1'b1;
            r_next.tx = r_reg.rword[15:8];
            r_next.sda_oe = ~r_reg.rword[15];
            r_next.st = D_TX;
          end
        end
        default: begin
          r_next.st = D_IDLE;
          r_next.sda_oe = 1'b0;
        end
      endcase
    end
  end

  // ********************************************************
  // Registers
  // ********************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r_reg <= RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // Open-drain drive: only ever a low level.
  assign bus.sda_dev_o = 1'b0;
  assign bus.sda_dev_oe = r_reg.sda_oe;
  assign bus.int_dev_o = 1'b0;
  assign bus.int_dev_oe = r_reg.int_oe;
  assign conf_word = r_reg.regs[0];
  assign high_thr = r_reg.regs[1];
  assign low_thr = r_reg.regs[2];
  assign power_word = r_reg.regs[3];
  assign busy = (r_reg.st != D_IDLE);
endmodule // light_i2c_target
`default_nettype wire

/* hw/light_i2c_host.sv */
/*
  Controller end of the two-wire word link: word writes and word reads
  by command code. Makes the serial clock by dividing clk.
  Assumes a target that does not stretch the clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "light_i2c_params.svh"
module light_i2c_host #(
  parameter int unsigned QTR_CYC = `SCL_QTR_CYC
) (
  input wire logic clk,                  // System clock.
  input wire logic resetn,               // Asynchronous reset, low.
  light_i2c_if.ctrl bus,                 // Serial link pins.
  input wire logic go,                   // Start a transfer, pulse.
  input wire logic rd,                   // 1 read word, 0 write word.
  input wire logic [6:0] dev_addr,       // Target address.
  input wire logic [7:0] cmd,            // Command code.
  input wire logic [15:0] wdata,         // Word to write.
  output logic busy,                     // Transfer in progress.
  output logic done,                     // Transfer over, pulse.
  output logic nack,                     // Last transfer refused.
  output logic [15:0] rdata              // Word read.
);
  import light_i2c_pkg::*;

  localparam host_reg_t RST = '{sda_m: 1'b1, sda_s: 1'b1,
    st: H_IDLE, default: '0};

  host_reg_t r_reg, r_next;
  logic tick, recv;

  // Byte sent in each slot of the sequence.
  function automatic logic [7:0] slot_byte(input host_reg_t r,
                                           input logic [2:0] i);
    logic [7:0] b;
    b = r.wdata[15:8];
    unique case (i)
      3'h0: b = {r.addr, 1'b0};
      3'h1: b = r.cmd;
      3'h2: b = r.rd ? {r.addr, 1'b1} : r.wdata[7:0];
      default: b = r.wdata[15:8];
    endcase
    return b;
  endfunction

  // ********************************************************
  // Serial clock divider and sequencer
  // ********************************************************
  // Four quarter periods per bit keep the rate at or below the max.
  assign tick = (r_reg.div == 13'(QTR_CYC - 1));
  assign recv = r_reg.rd & (r_reg.idx >= 3'h3);

  always_comb begin
    r_next = r_reg;
    r_next.sda_m = bus.sda;
    r_next.sda_s = r_reg.sda_m;
    r_next.done = 1'b0;
    r_next.div = (tick || r_reg.st == H_IDLE) ? 13'h0000 :
                 r_reg.div + 13'h0001;
    if (tick) begin
      r_next.ph = r_reg.ph + 2'h1;
    end
    unique case (r_reg.st)
      H_IDLE: begin
        r_next.scl_oe = 1'b0;
        r_next.sda_oe = 1'b0;
        r_next.ph = 2'h0;
        if (go) begin
          r_next.rd = rd;
          r_next.addr = dev_addr;
          r_next.cmd = cmd;
          r_next.wdata = wdata;
          r_next.idx = 3'h0;
          r_next.nack = 1'b0;
          r_next.st = H_START;
        end
      end
      H_START: if (tick) begin
        // Also a repeated start: release data, then clock, then pull.
        unique case (r_reg.ph)
          2'h0: r_next.sda_oe = 1'b0;
          2'h1: r_next.scl_oe = 1'b0;
          2'h2: r_next.sda_oe = 1'b1;
          2'h3: begin
            r_next.scl_oe = 1'b1;
            r_next.bitn = 4'h0;
            r_next.tx = slot_byte(r_reg, r_reg.idx);
            r_next.st = H_BITS;
          end
        endcase
      end
      H_BITS: if (tick) begin
        unique case (r_reg.ph)
          2'h0: begin
            if (r_reg.bitn != 4'h8) begin
              r_next.sda_oe = recv ? 1'b0 : ~r_reg.tx[7];
            end else begin
              r_next.sda_oe = recv && r_reg.idx == 3'h3;
            end
          end
          2'h1: r_next.scl_oe = 1'b0;
          2'h2: begin
            if (r_reg.bitn != 4'h8) begin
              r_next.rx = {r_reg.rx[6:0], r_reg.sda_s};
            end else begin
              r_next.ack_bad = r_reg.sda_s;
            end
          end
          2'h3: begin
            r_next.scl_oe = 1'b1;
            r_next.tx = {r_reg.tx[6:0], 1'b0};
            r_next.bitn = r_reg.bitn + 4'h1;
            if (r_reg.bitn == 4'h8) begin
              r_next.bitn = 4'h0;
              r_next.idx = r_reg.idx + 3'h1;
              r_next.tx = slot_byte(r_reg, r_reg.idx + 3'h1);
              if (!recv && r_reg.ack_bad) begin
                r_next.nack = 1'b1;
                r_next.st = H_STOP;
              end else if (!r_reg.rd && r_reg.idx == 3'h3) begin
                r_next.st = H_STOP;
              end else if (r_reg.rd && r_reg.idx == 3'h1) begin
                r_next.st = H_START;
              end else if (r_reg.rd && r_reg.idx == 3'h3) begin
                r_next.rdata[7:0] = r_reg.rx;
              end else if (r_reg.rd && r_reg.idx == 3'h4) begin
                r_next.rdata[15:8] = r_reg.rx;
                r_next.st = H_STOP;
              end
            end
          end
        endcase
      end
      H_STOP: if (tick) begin
        unique case (r_reg.ph)
          2'h0: r_next.sda_oe = 1'b1;
          2'h1: r_next.scl_oe = 1'b0;
          2'h2: r_next.sda_oe = 1'b0;
          2'h3: begin
            r_next.done = 1'b1;
            r_next.st = H_IDLE;
          end
        endcase
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r_reg <= RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign bus.scl_host_o = 1'b0;
  assign bus.scl_host_oe = r_reg.scl_oe;
  assign bus.sda_host_o = 1'b0;
  assign bus.sda_host_oe = r_reg.sda_oe;
  assign busy = (r_reg.st != H_IDLE);
  assign done = r_reg.done;
  assign nack = r_reg.nack;
  assign rdata = r_reg.rdata;
endmodule // light_i2c_host
`default_nettype wire

/* verif/light_i2c_monitor.sv */
/*
  Checker for the wires between the two ends of the word link.
  Assumes one clk domain and the resolved wires of the interface.
*/
`timescale 1ns/10ps
`default_nettype none
module light_i2c_monitor #(
  parameter int unsigned QTR_CYC = 16
) (
  input wire logic clk,         // System clock.
  input wire logic resetn,      // Asynchronous reset, low.
  input wire logic scl_host_o,  // Controller clock level.
  input wire logic scl_host_oe, // Controller clock drive.
  input wire logic sda_host_o,  // Controller data level.
  input wire logic sda_host_oe, // Controller data drive.
  input wire logic sda_dev_o,   // Target data level.
  input wire logic sda_dev_oe,  // Target data drive.
  input wire logic int_dev_o,   // Interrupt level.
  input wire logic int_dev_oe,  // Interrupt drive.
  input wire logic scl,         // Resolved clock wire.
  input wire logic sda,         // Resolved data wire.
  input wire logic int_n        // Resolved interrupt wire.
);
  // ****************************************
  // Frame tracking
  // ****************************************
  localparam int LOW_CYC = 2 * QTR_CYC;
  localparam int BYTE_CYC = 40 * QTR_CYC;
  logic scl_q, sda_q, in_frame, first;
  logic [3:0] bits;
  logic [15:0] run;

  // Run holds how long the previous scl level lasted when scl changes.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      in_frame <= 1'b0;
      first <= 1'b0;
      bits <= 4'h0;
      run <= 16'h0000;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      run <= (scl != scl_q) ? 16'h0001 : run + 16'h0001;
      if (scl && scl_q && sda_q && !sda) begin
        in_frame <= 1'b1;
        first <= 1'b1;
        bits <= 4'h0;
      end else if (scl && scl_q && !sda_q && sda) begin
        in_frame <= 1'b0;
      end else if (scl && !scl_q) begin
        bits <= (bits == 4'h8) ? 4'h0 : bits + 4'h1;
        first <= first && (bits != 4'h8);
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  a_int_open_drain: assert property (
    int_dev_oe |-> !int_dev_o) else $error("Interrupt pin driven high.");
  a_sda_open_drain: assert property (
    sda_dev_oe |-> !sda_dev_o) else $error("Target drove data high.");
  a_scl_open_drain: assert property (
    scl_host_oe |-> !scl_host_o) else $error("Clock driven high.");
  a_sda_host_od: assert property (
    sda_host_oe |-> !sda_host_o) else $error("Controller drove data high.");
  a_scl_low_time: assert property (
    $rose(scl) |-> run == LOW_CYC) else $error("Clock low time wrong.");
  a_dev_data_stable: assert property (
    (scl && $past(scl)) |-> $stable(sda_dev_oe))
    else $error("Target data moved while clock high.");
  a_addr_quiet: assert property (
    (first && bits < 4'h8) |-> !sda_dev_oe)
    else $error("Target drove data during address bits.");
  a_ack_hold: assert property (
    $rose(sda_dev_oe) |-> sda_dev_oe [*8])
    else $error("Target low drive too short.");
  a_drive_bounded: assert property (
    sda_dev_oe |-> ##[0:BYTE_CYC] !sda_dev_oe)
    else $error("Target held data low too long.");
  a_idle_quiet: assert property (
    !in_frame |-> !sda_dev_oe) else $error("Target drove data outside frame.");
endmodule // light_i2c_monitor
`default_nettype wire

/* verif/test_sensor_i2c_word_target.sv */
/*
  Self-checking bench: controller and target joined by one link, plus a
  second target whose link the bench holds low to force a bus timeout.
  Assumes the design package and constants header on the include path.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    compares++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
module test_sensor_i2c_word_target;
  import light_i2c_pkg::*;
  localparam int unsigned QTR = 16;
  localparam int unsigned TMO = 2000;
  typedef struct packed {
    logic s, rd;
    logic [6:0] a;
    logic [7:0] c;
    logic [15:0] d, e;
    logic n;
  } row_t;
  logic clk, resetn, go, rd, done, nack, hbusy, tbusy, bbusy, strap, int_req;
  logic [6:0] addr;
  logic [7:0] cmd;
  logic [15:0] wdata, rdata, conf, hthr, lthr, pwr;
  logic [15:0] als, white, flags;
  int errors, compares;
  row_t rows [16];
  light_i2c_if bus();
  light_i2c_if bus_b();

  // ****************************************
  // Design ends and checker
  // ****************************************
  light_i2c_host #(.QTR_CYC(QTR)) u_light_i2c_host (.clk(clk),
    .resetn(resetn), .bus(bus), .go(go), .rd(rd), .dev_addr(addr),
    .cmd(cmd), .wdata(wdata), .busy(hbusy), .done(done), .nack(nack),
    .rdata(rdata));
  light_i2c_target #(.TIMEOUT_CYC(TMO)) u_light_i2c_target (.clk(clk),
    .resetn(resetn), .bus(bus), .addr_strap(strap), .als_data(als),
    .white_data(white), .int_flags(flags), .int_req(int_req),
    .conf_word(conf), .high_thr(hthr), .low_thr(lthr), .power_word(pwr),
    .busy(tbusy));
  // Second target sees only bench-driven wires, to break the low-time limit.
  light_i2c_target #(.TIMEOUT_CYC(TMO)) u_light_i2c_target_b (.clk(clk),
    .resetn(resetn), .bus(bus_b), .addr_strap(strap),
    .als_data(als), .white_data(white), .int_flags(flags),
    .int_req(int_req), .conf_word(), .high_thr(), .low_thr(),
    .power_word(), .busy(bbusy));
  light_i2c_monitor #(.QTR_CYC(QTR)) u_light_i2c_monitor (.clk(clk),
    .resetn(resetn), .scl_host_o(bus.scl_host_o),
    .scl_host_oe(bus.scl_host_oe), .sda_host_o(bus.sda_host_o),
    .sda_host_oe(bus.sda_host_oe), .sda_dev_o(bus.sda_dev_o),
    .sda_dev_oe(bus.sda_dev_oe), .int_dev_o(bus.int_dev_o),
    .int_dev_oe(bus.int_dev_oe), .scl(bus.scl), .sda(bus.sda),
    .int_n(bus.int_n));

  // ****************************************
  // Helpers
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Only the low two command bits select a writable word.
  function automatic logic [15:0] word(input logic [7:0] c);
    case (c[1:0])
      2'h0: word = conf;
      2'h1: word = hthr;
      2'h2: word = lthr;
      default: word = pwr;
    endcase
  endfunction

  // One transfer: go for one cycle, then wait on done with a bound.
  task automatic xfer(input row_t r);
    int k;
    @(negedge clk);
    strap = r.s;
    rd = r.rd;
    addr = r.a;
    cmd = r.c;
    wdata = r.d;
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    for (k = 0; k < 20000 && done !== 1'b1; k++) @(negedge clk);
    `CHK(done, 1'b1)
    @(negedge clk);
  endtask

  task automatic stop_test;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // A hang costs far less than this span; the whole run needs about 206k ns.
  initial begin
    #400000;
    errors++;
    stop_test();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {resetn, go, rd, addr, cmd, wdata, int_req} = '0;
    strap = 1'b1;
    {als, white, flags} = {16'hbeef, 16'hc0de, 16'h0f0f};
    errors = 0;
    compares = 0;
    {bus_b.scl_host_o, bus_b.scl_host_oe} = 2'b00;
    {bus_b.sda_host_o, bus_b.sda_host_oe} = 2'b00;
    rows[0] = '{1, 0, 7'h48, 8'h00, 16'ha55a, 16'ha55a, 0};
    rows[1] = '{1, 0, 7'h48, 8'h01, 16'h1234, 16'h1234, 0};
    rows[2] = '{1, 0, 7'h48, 8'h02, 16'h8001, 16'h8001, 0};
    rows[3] = '{1, 0, 7'h48, 8'h03, 16'h00fe, 16'h00fe, 0};
    rows[4] = '{1, 0, 7'h48, 8'h04, 16'hffff, 16'h0000, 0};
    rows[5] = '{1, 1, 7'h48, 8'h00, 16'h0000, 16'ha55a, 0};
    rows[6] = '{1, 1, 7'h48, 8'h01, 16'h0000, 16'h1234, 0};
    rows[7] = '{1, 1, 7'h48, 8'h04, 16'h0000, 16'hbeef, 0};
    rows[8] = '{1, 1, 7'h48, 8'h05, 16'h0000, 16'hc0de, 0};
    rows[9] = '{1, 1, 7'h48, 8'h06, 16'h0000, 16'h0f0f, 0};
    rows[10] = '{1, 1, 7'h48, 8'h07, 16'h0000, 16'h0000, 0};
    rows[11] = '{1, 0, 7'h10, 8'h00, 16'h5555, 16'ha55a, 1};
    rows[12] = '{0, 0, 7'h10, 8'h02, 16'h4321, 16'h4321, 0};
    rows[13] = '{0, 1, 7'h10, 8'h02, 16'h0000, 16'h4321, 0};
    rows[14] = '{0, 0, 7'h48, 8'h01, 16'h9999, 16'h1234, 1};
    rows[15] = '{0, 1, 7'h48, 8'h00, 16'h0000, 16'h0000, 1};
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    `CHK(conf, 16'h0001)
    `CHK(({hthr, lthr, pwr, rdata}), 64'h0)
    `CHK(({hbusy, tbusy, done, nack}), 4'h0)
    // Table of transfers, both strap levels and refused addresses.
    foreach (rows[i]) begin
      xfer(rows[i]);
      `CHK(nack, rows[i].n)
      if (rows[i].rd && !rows[i].n)
        `CHK(rdata, rows[i].e)
      else if (!rows[i].rd && rows[i].c < 8'h04)
        `CHK(word(rows[i].c), rows[i].e)
    end
    // Interrupt wire follows the request one flop later.
    int_req = 1'b1;
    repeat (3) @(negedge clk);
    `CHK(bus.int_n, 1'b0)
    int_req = 1'b0;
    repeat (3) @(negedge clk);
    `CHK(bus.int_n, 1'b1)
    // Reset in mid-transfer must free both lines and restore the configuration word.
    {strap, rd, addr, cmd, go} = {2'b10, 7'h48, 8'h00, 1'b1};
    @(negedge clk);
    go = 1'b0;
    repeat (700) @(negedge clk);
    `CHK(({hbusy, tbusy}), 2'h3)
    resetn = 1'b0;
    @(negedge clk);
    `CHK(({bus.scl, bus.sda, hbusy, tbusy, conf}), {4'hc, 16'h0001})
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    // Start on the second link, then hold clock low past the limit.
    bus_b.sda_host_oe = 1'b1;
    repeat (20) @(negedge clk);
    `CHK(bbusy, 1'b1)
    bus_b.scl_host_oe = 1'b1;
    repeat (TMO - 100) @(negedge clk);
    `CHK(bbusy, 1'b1)
    repeat (200) @(negedge clk);
    `CHK(bbusy, 1'b0)
    bus_b.scl_host_oe = 1'b0;
    repeat (20) @(negedge clk);
    bus_b.sda_host_oe = 1'b0;
    stop_test();
  end
endmodule // test_sensor_i2c_word_target
`default_nettype wire
